// *** verilog/lsb_line_buffer.sv ***
// Line-scan buffer: command decoder, line store and serial output sequencer
// Overview of operation
// RULE1: code 0110 loads preamble length, kept between 3 and 4095.
// RULE2: with preamble enabled, fill bits go out on every send entry.
// RULE3: preamble value n gives n+1 fill bits before stored words.
// RULE4: serial clock keeps running during preamble bits.
// RULE5: in LIFO order the preamble still completes before reversed words.
// RULE6: code 0100 selects FIFO/LIFO and MSB/LSB first.
// RULE7: code 0000 stores a 4-bit mode value choosing write or send.
// RULE8: in cascaded setups send and inversion need two words.
// RULE9: write entry with mask bit set in request mode keeps request high.
// RULE10: host sets mask bit on write entry before a fill-line command.
// RULE11: host uses either inversion command or toggle pin, never both.
// RULE12: code 0011 fills the programmed word count with fill data.
// RULE13: fill line sends (n+1)+(w+1)*16 fill bits with clock.
// RULE14: code 0010 resends the buffer once current sending ends.
// RULE15: in cascaded setups host follows repeat with mode second word.
// RULE16: stop code 1111 is taken in every mode.
// RULE17: stop clears all but init, format, word count, preamble length.
// RULE18: host issues stop before static-only commands.
// RULE19: writes with command select high are commands, low are data; code takes any write with dack_n_i low as data, whatever command select is.
// RULE20: request goes low on write entry, high after N+1 words.
// RULE21: reset clears every mode flag and bit.
`timescale 1ns/1ps
`include "lsb_regs.svh"
module lsb_line_buffer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Parallel bus pins
  input  wire logic        cs_n_i,
  input  wire logic        wr_n_i,
  input  wire logic        dack_n_i,
  input  wire logic        cmd_sel_i,
  input  wire logic [15:0] data_i,
  // Serial link and host transfer request
  input  wire logic        link_clk_i,
  output logic             ser_data_o,
  output logic             ser_clk_o,
  output logic             transfer_request_line_n_o
);
  lsb_pkg::lsb_state_s st_ff;
  lsb_pkg::lsb_state_s nxt_st;
  logic [15:0]         mem [0:319];
  logic                strobe;
  logic                cmd_take;
  logic                data_take;
  logic                fall;
  logic                expire;
  logic                run;
  logic                start;
  logic                go_write;
  logic                mem_we;
  logic [9:0]          total;
  logic [8:0]          rd_idx;
  logic [15:0]         cur_word;
  logic [3:0]          code;

  function automatic logic [2:0] half_lim(input logic [2:0] sel);
    case (sel)
      `LSB_DIV_SEL4:  half_lim = `LSB_HALF4;
      `LSB_DIV_SEL8:  half_lim = `LSB_HALF8;
      `LSB_DIV_SEL16: half_lim = `LSB_HALF16;
      default:        half_lim = `LSB_HALF2;
    endcase
  endfunction

  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.bus_m    = {cs_n_i, wr_n_i, dack_n_i, cmd_sel_i};
    nxt_st.bus_s    = st_ff.bus_m;
    nxt_st.data_m   = data_i;
    nxt_st.data_s   = st_ff.data_m;
    nxt_st.link_m   = link_clk_i;
    nxt_st.link_s   = st_ff.link_m;
    nxt_st.link_prev = st_ff.link_s;
    nxt_st.wr_n_prev = st_ff.bus_s[`LSB_BUS_WR];
    mem_we   = 1'b0;
    start    = 1'b0;
    go_write = 1'b0;
    expire   = 1'b0;
    run      = 1'b0;
    fall     = 1'b0;
    code     = st_ff.data_s[`LSB_CODE];
    // Write taken at the strobe's trailing edge, when the bus data is settled
    strobe   = st_ff.bus_s[`LSB_BUS_WR] && !st_ff.wr_n_prev;
    cmd_take = strobe && !st_ff.bus_s[`LSB_BUS_CS] && st_ff.bus_s[`LSB_BUS_DACK]
               && st_ff.bus_s[`LSB_BUS_CD]; // see RULE19
    data_take = strobe && (!st_ff.bus_s[`LSB_BUS_DACK]
               || (!st_ff.bus_s[`LSB_BUS_CS] && !st_ff.bus_s[`LSB_BUS_CD])); // see RULE19
    total    = st_ff.fill_line ? {1'b0, st_ff.fill_words} + 10'h001
                               : {1'b0, st_ff.wr_ptr}; // see RULE13
    rd_idx   = st_ff.lifo ? 9'(total - 10'h001 - {1'b0, st_ff.word_idx}) : st_ff.word_idx;
    cur_word = st_ff.fill_line ? {16{st_ff.fill_pol}} : mem[rd_idx]; // see RULE12
    // Bit clock: own divider or edges of the peripheral clock
    if (st_ff.clk_int)
    begin
      // Keeps going until the last bit has had its rising edge
      run    = st_ff.mode == lsb_pkg::LSB_ST_SEND
               && (st_ff.phase != lsb_pkg::LSB_PH_DONE || !st_ff.sclk);
      expire = st_ff.div_cnt == half_lim(st_ff.div_sel);
      fall   = run && expire && st_ff.sclk;
      if (!run)
      begin
        nxt_st.div_cnt = '0;
        nxt_st.sclk    = 1'b1;
      end
      else if (expire)
      begin
        nxt_st.div_cnt = '0;
        nxt_st.sclk    = !st_ff.sclk; // see RULE4
      end
      else
        nxt_st.div_cnt = st_ff.div_cnt + 3'h1;
    end
    else
    begin
      fall = st_ff.mode == lsb_pkg::LSB_ST_SEND && st_ff.phase != lsb_pkg::LSB_PH_DONE
             && st_ff.link_prev && !st_ff.link_s;
      nxt_st.sclk = st_ff.mode == lsb_pkg::LSB_ST_SEND ? st_ff.link_s : 1'b1; // see RULE4
    end
    // Serialiser: each bit is launched on a falling clock edge
    if (fall)
    begin
      unique case (st_ff.phase)
        lsb_pkg::LSB_PH_PRE:
        begin
          nxt_st.dout = st_ff.fill_pol; // see RULE2
          if (st_ff.pre_cnt == '0)
            nxt_st.phase = total == '0 ? lsb_pkg::LSB_PH_DONE : lsb_pkg::LSB_PH_DATA; // see RULE5
          else
            nxt_st.pre_cnt = st_ff.pre_cnt - 12'h001; // see RULE3
        end
        lsb_pkg::LSB_PH_DATA:
        begin
          nxt_st.dout    = cur_word[st_ff.lsb_first ? st_ff.bit_idx
                                                    : `LSB_WORD_MSB - st_ff.bit_idx];
          nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
          if (st_ff.bit_idx == `LSB_WORD_MSB)
          begin
            nxt_st.word_idx = st_ff.word_idx + 9'h001;
            if ({1'b0, st_ff.word_idx} + 10'h001 == total)
              nxt_st.phase = lsb_pkg::LSB_PH_DONE;
          end
        end
        lsb_pkg::LSB_PH_DONE:
        begin
        end
      endcase
    end
    if (st_ff.mode == lsb_pkg::LSB_ST_SEND && st_ff.phase == lsb_pkg::LSB_PH_DONE
        && st_ff.repeat_req)
    begin
      start = 1'b1; // see RULE14
      nxt_st.repeat_req = 1'b0;
    end
    // Line store writes and request count
    if (data_take && st_ff.mode == lsb_pkg::LSB_ST_WRITE)
    begin
      if (!st_ff.fill_line && st_ff.wr_ptr < `LSB_MEM_WORDS)
      begin
        mem_we = 1'b1;
        nxt_st.wr_ptr = st_ff.wr_ptr + 9'h001;
      end
      if (!st_ff.req_n)
      begin
        nxt_st.req_cnt = st_ff.req_cnt + 9'h001;
        if (st_ff.req_cnt == st_ff.req_words)
          nxt_st.req_n = 1'b1; // see RULE20
      end
    end
    // Commands; setup commands only count in static mode
    if (cmd_take)
    begin
      case (code)
        `LSB_CMD_MODE:
        begin
          nxt_st.op_bits = st_ff.data_s[`LSB_OP_BITS]; // see RULE7
          if ((st_ff.ext32 || st_ff.ext_tog) && !st_ff.first_word
              && (st_ff.data_s[`LSB_OP] == `LSB_OP_SEND
              || st_ff.data_s[`LSB_OP] == `LSB_OP_INV1))
            nxt_st.first_word = 1'b1; // see RULE8
          else
          begin
            nxt_st.first_word = 1'b0;
            if (st_ff.data_s[`LSB_OP] == `LSB_OP_WRITE)
              go_write = 1'b1;
            else if (st_ff.data_s[`LSB_OP] == `LSB_OP_SEND)
              start = 1'b1;
            else if (st_ff.data_s[`LSB_OP] == `LSB_OP_INV2 && st_ff.first_word)
            begin
              go_write = st_ff.mode == lsb_pkg::LSB_ST_SEND; // see RULE8
              start    = st_ff.mode == lsb_pkg::LSB_ST_WRITE;
            end
          end
        end
        `LSB_CMD_REPEAT:
          if (st_ff.mode == lsb_pkg::LSB_ST_SEND)
            nxt_st.repeat_req = 1'b1; // see RULE14
        `LSB_CMD_FILL:
          if (st_ff.mode == lsb_pkg::LSB_ST_WRITE)
          begin
            nxt_st.fill_line  = 1'b1; // see RULE12
            nxt_st.fill_words = st_ff.data_s[`LSB_WORDS];
            nxt_st.req_n      = 1'b1;
          end
        `LSB_CMD_FMT:
          if (st_ff.mode == lsb_pkg::LSB_ST_STATIC)
          begin
            nxt_st.lifo      = st_ff.data_s[`LSB_FMT_LIFO]; // see RULE6
            nxt_st.lsb_first = st_ff.data_s[`LSB_FMT_LSBF];
          end
        `LSB_CMD_PRE:
          if (st_ff.mode == lsb_pkg::LSB_ST_STATIC)
            nxt_st.pre_len = st_ff.data_s[`LSB_PRE_LEN] < `LSB_PRE_MIN ? `LSB_PRE_MIN
                             : st_ff.data_s[`LSB_PRE_LEN]; // see RULE1
        `LSB_CMD_REQN:
          if (st_ff.mode == lsb_pkg::LSB_ST_STATIC)
            nxt_st.req_words = st_ff.data_s[`LSB_WORDS];
        `LSB_CMD_INIT:
          if (st_ff.mode == lsb_pkg::LSB_ST_STATIC)
          begin
            nxt_st.clk_int  = st_ff.data_s[`LSB_INIT_CLKINT];
            nxt_st.div_sel  = st_ff.data_s[`LSB_INIT_DIV];
            nxt_st.ext32    = st_ff.data_s[`LSB_INIT_EXT32];
            nxt_st.ext_tog  = st_ff.data_s[`LSB_INIT_TOG];
            nxt_st.req_mode = st_ff.data_s[`LSB_INIT_REQ];
            nxt_st.pre_en   = st_ff.data_s[`LSB_INIT_PRE];
            nxt_st.fill_pol = st_ff.data_s[`LSB_INIT_POL];
          end
        `LSB_CMD_STOP:
        begin
          // Setup registers survive a stop
          start             = 1'b0; // see RULE16
          nxt_st.mode       = lsb_pkg::LSB_ST_STATIC; // see RULE17
          nxt_st.phase      = lsb_pkg::LSB_PH_DONE;
          nxt_st.op_bits    = '0;
          nxt_st.fill_line  = 1'b0;
          nxt_st.wr_ptr     = '0;
          nxt_st.req_cnt    = '0;
          nxt_st.req_n      = 1'b1;
          nxt_st.first_word = 1'b0;
          nxt_st.repeat_req = 1'b0;
          nxt_st.word_idx   = '0;
          nxt_st.bit_idx    = '0;
          nxt_st.pre_cnt    = '0;
        end
        default:
        begin
        end
      endcase
    end
    if (go_write)
    begin
      nxt_st.mode      = lsb_pkg::LSB_ST_WRITE;
      nxt_st.phase     = lsb_pkg::LSB_PH_DONE;
      nxt_st.wr_ptr    = '0;
      nxt_st.fill_line = 1'b0;
      nxt_st.req_cnt   = '0;
      nxt_st.req_n     = !(st_ff.req_mode && !st_ff.data_s[`LSB_MASK_BIT]); // see RULE9
    end
    if (start)
    begin
      nxt_st.mode     = lsb_pkg::LSB_ST_SEND;
      nxt_st.phase    = st_ff.pre_en ? lsb_pkg::LSB_PH_PRE
                      : (total == '0 ? lsb_pkg::LSB_PH_DONE : lsb_pkg::LSB_PH_DATA); // see RULE2
      nxt_st.pre_cnt  = st_ff.pre_len;
      nxt_st.word_idx = '0;
      nxt_st.bit_idx  = '0;
      nxt_st.req_n    = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_ff           <= '0; // see RULE21
      st_ff.mode      <= lsb_pkg::LSB_ST_STATIC;
      st_ff.phase     <= lsb_pkg::LSB_PH_DONE;
      st_ff.req_n     <= 1'b1;
      st_ff.sclk      <= 1'b1;
      st_ff.bus_m     <= `LSB_BUS_IDLE;
      st_ff.bus_s     <= `LSB_BUS_IDLE;
      st_ff.wr_n_prev <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // Line store has no reset; contents are defined only once written
  always_ff @(posedge clk_i)
  begin
    if (mem_we)
      mem[st_ff.wr_ptr] <= st_ff.data_s;
  end

  assign ser_data_o                = st_ff.dout;
  assign ser_clk_o                 = st_ff.sclk;
  assign transfer_request_line_n_o = st_ff.req_n;

  // Checks
  logic [11:0] pre_bits;
  always_ff @(posedge clk_i)
  begin
    if (reset_i || start)
      pre_bits <= '0;
    else if (fall && st_ff.phase == lsb_pkg::LSB_PH_PRE)
      pre_bits <= pre_bits + 12'h001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_pre_len_min: assert property ((cmd_take && code == `LSB_CMD_PRE
    && st_ff.mode == lsb_pkg::LSB_ST_STATIC) |=> st_ff.pre_len >= `LSB_PRE_MIN) // see RULE1
    else $error("preamble length below minimum");
  chk_pre_fill_bit: assert property ((fall && st_ff.phase == lsb_pkg::LSB_PH_PRE)
    |=> ser_data_o == st_ff.fill_pol) // see RULE2
    else $error("preamble bit not fill level");
  chk_pre_bit_count: assert property ((fall && st_ff.phase == lsb_pkg::LSB_PH_PRE
    && st_ff.pre_cnt == '0) |-> pre_bits == st_ff.pre_len) // see RULE3
    else $error("preamble bit count wrong");
  chk_pre_clock_runs: assert property ((st_ff.phase == lsb_pkg::LSB_PH_PRE
    && st_ff.mode == lsb_pkg::LSB_ST_SEND && st_ff.clk_int)
    |-> ##[1:16] $changed(ser_clk_o)) // see RULE4
    else $error("serial clock stalled in preamble");
  chk_lifo_after_pre: assert property ((st_ff.phase == lsb_pkg::LSB_PH_DATA
    && $past(st_ff.phase) == lsb_pkg::LSB_PH_PRE) |-> st_ff.word_idx == '0
    && pre_bits == st_ff.pre_len + 12'h001) // see RULE5
    else $error("data began before preamble end");
  chk_fmt_store: assert property ((cmd_take && code == `LSB_CMD_FMT
    && st_ff.mode == lsb_pkg::LSB_ST_STATIC)
    |=> st_ff.lifo == $past(st_ff.data_s[`LSB_FMT_LIFO])) // see RULE6
    else $error("format not stored");
  chk_mode_store: assert property ((cmd_take && code == `LSB_CMD_MODE)
    |=> st_ff.op_bits == $past(st_ff.data_s[`LSB_OP_BITS])) // see RULE7
    else $error("mode bits not stored");
  chk_req_mask: assert property ((go_write && st_ff.data_s[`LSB_MASK_BIT])
    |=> transfer_request_line_n_o) // see RULE9
    else $error("request driven despite mask");
  chk_fill_store: assert property ((cmd_take && code == `LSB_CMD_FILL
    && st_ff.mode == lsb_pkg::LSB_ST_WRITE) |=> st_ff.fill_line && transfer_request_line_n_o
    && st_ff.fill_words == $past(st_ff.data_s[`LSB_WORDS])) // see RULE12
    else $error("fill line not taken");
  chk_repeat_restart: assert property ((st_ff.mode == lsb_pkg::LSB_ST_SEND
    && st_ff.phase == lsb_pkg::LSB_PH_DONE && st_ff.repeat_req && !cmd_take)
    |=> st_ff.mode == lsb_pkg::LSB_ST_SEND && !st_ff.repeat_req) // see RULE14
    else $error("repeat not started");
  chk_stop_keeps: assert property ((cmd_take && code == `LSB_CMD_STOP)
    |=> st_ff.mode == lsb_pkg::LSB_ST_STATIC && st_ff.pre_len == $past(st_ff.pre_len)
    && st_ff.wr_ptr == '0) // see RULE17
    else $error("stop did not clear correctly");
  chk_req_release: assert property ((data_take && st_ff.mode == lsb_pkg::LSB_ST_WRITE
    && !st_ff.req_n && st_ff.req_cnt == st_ff.req_words)
    |=> transfer_request_line_n_o) // see RULE20
    else $error("request not released");
  cov_send_pre: cover property (st_ff.phase == lsb_pkg::LSB_PH_PRE
    ##[1:1000] st_ff.phase == lsb_pkg::LSB_PH_DATA);
  cov_fill_send: cover property (st_ff.fill_line && st_ff.phase == lsb_pkg::LSB_PH_DATA);
  cov_repeat: cover property (st_ff.repeat_req && st_ff.phase == lsb_pkg::LSB_PH_DONE);
  cov_stop_send: cover property (cmd_take && code == `LSB_CMD_STOP
    && st_ff.mode == lsb_pkg::LSB_ST_SEND);
endmodule

// *** verilog/lsb_regs.svh ***
// Command codes, field positions and constants of the line-scan buffer
`ifndef LSB_REGS_SVH
`define LSB_REGS_SVH
`define LSB_CODE        15:12
`define LSB_CMD_MODE    4'h0
`define LSB_CMD_REPEAT  4'h2
`define LSB_CMD_FILL    4'h3
`define LSB_CMD_FMT     4'h4
`define LSB_CMD_PRE     4'h6
`define LSB_CMD_REQN    4'h7
`define LSB_CMD_INIT    4'h8
`define LSB_CMD_STOP    4'hf
`define LSB_OP          2:0
`define LSB_OP_BITS     3:0
`define LSB_OP_WRITE    3'h0
`define LSB_OP_SEND     3'h1
`define LSB_OP_INV1     3'h4
`define LSB_OP_INV2     3'h6
`define LSB_MASK_BIT    3
`define LSB_INIT_CLKINT 11
`define LSB_INIT_DIV    10:8
`define LSB_INIT_EXT32  4
`define LSB_INIT_TOG    3
`define LSB_INIT_REQ    2
`define LSB_INIT_PRE    1
`define LSB_INIT_POL    0
`define LSB_FMT_LIFO    1
`define LSB_FMT_LSBF    0
`define LSB_PRE_LEN     11:0
`define LSB_WORDS       8:0
`define LSB_PRE_MIN     12'h003
`define LSB_MEM_WORDS   9'd320
`define LSB_WORD_MSB    4'hf
`define LSB_DIV_SEL4    3'h2
`define LSB_DIV_SEL8    3'h3
`define LSB_DIV_SEL16   3'h4
`define LSB_HALF2       3'h0
`define LSB_HALF4       3'h1
`define LSB_HALF8       3'h3
`define LSB_HALF16      3'h7
`define LSB_BUS_CS      3
`define LSB_BUS_WR      2
`define LSB_BUS_DACK    1
`define LSB_BUS_CD      0
`define LSB_BUS_IDLE    4'hf
`endif

// *** verilog/lsb_pkg.sv ***
// Types of the line-scan buffer command decoder
package lsb_pkg;
  typedef enum logic [2:0] {
    LSB_ST_STATIC = 3'b001,
    LSB_ST_WRITE  = 3'b010,
    LSB_ST_SEND   = 3'b100
  } lsb_mode_e;
  typedef enum logic [2:0] {
    LSB_PH_PRE  = 3'b001,
    LSB_PH_DATA = 3'b010,
    LSB_PH_DONE = 3'b100
  } lsb_phase_e;
  typedef struct packed {
    lsb_mode_e   mode;
    lsb_phase_e  phase;
    logic [3:0]  op_bits;
    logic        clk_int;
    logic [2:0]  div_sel;
    logic        ext32;
    logic        ext_tog;
    logic        req_mode;
    logic        pre_en;
    logic        fill_pol;
    logic        lifo;
    logic        lsb_first;
    logic [8:0]  req_words;
    logic [11:0] pre_len;
    logic [8:0]  fill_words;
    logic        fill_line;
    logic [8:0]  wr_ptr;
    logic [8:0]  req_cnt;
    logic        req_n;
    logic        first_word;
    logic        repeat_req;
    logic [11:0] pre_cnt;
    logic [8:0]  word_idx;
    logic [3:0]  bit_idx;
    logic [2:0]  div_cnt;
    logic        sclk;
    logic        dout;
    logic [3:0]  bus_m;
    logic [3:0]  bus_s;
    logic        wr_n_prev;
    logic [15:0] data_m;
    logic [15:0] data_s;
    logic        link_m;
    logic        link_s;
    logic        link_prev;
  } lsb_state_s;
endpackage

// *** tb/lsb_host_model.sv ***
// Host bus model that writes command and data words to the line buffer
`timescale 1ns/1ps
module lsb_host_model (
  // Clock
  input  wire logic        clk_i,
  // Bus pins driven by the host
  output logic             cs_n_o,
  output logic             wr_n_o,
  output logic             dack_n_o,
  output logic             cmd_sel_o,
  output logic [15:0]      data_o
);
  initial
  begin
    cs_n_o    = 1'b1;
    wr_n_o    = 1'b1;
    dack_n_o  = 1'b1;
    cmd_sel_o = 1'b1;
    data_o    = 16'h0000;
  end

  // Strobe phases of 4 clocks cover the three-flop sampler in the device
  // Mode inversion only ever goes through the command, no toggle pin
  task automatic write_word(input logic cmd, input logic dma, input logic [15:0] word);
    @(posedge clk_i);
    cs_n_o    <= dma;
    dack_n_o  <= ~dma;
    cmd_sel_o <= cmd;
    data_o    <= word;
    wr_n_o    <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o    <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_n_o    <= 1'b1;
    dack_n_o  <= 1'b1;
    // Released bus shows the inverse, never a stale copy
    data_o    <= ~word;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the line-scan buffer command decoder
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        cs_n;
  logic        wr_n;
  logic        dack_n;
  logic        cmd_sel;
  logic [15:0] data;
  logic        link_clk = 1'b1;
  logic        link_run = 1'b0;
  logic        ser_data;
  logic        ser_clk;
  logic        req_n;
  logic        sclk_prev = 1'b1;
  logic        got_q[$];
  logic        exp_q[$];
  logic [15:0] words[8];
  int          n_fail = 0;
  int          comparisons = 0;
  int          it;
  int          pre;
  int          pre_cmd;
  int          nw;
  int          k;
  logic        pol;
  logic        lifo;
  logic        lsbf;
  logic        intc;
  logic        pre_en;
  logic        ext32;
  logic [2:0]  div;

  always #2 clk_i = ~clk_i;

  // Link clock runs only inside frames and parks high
  initial
  begin
    #37;
    forever #80 if (link_run || !link_clk) link_clk = ~link_clk;
  end

  lsb_host_model u_host (
    .clk_i     (clk_i),
    .cs_n_o    (cs_n),
    .wr_n_o    (wr_n),
    .dack_n_o  (dack_n),
    .cmd_sel_o (cmd_sel),
    .data_o    (data)
  );

  lsb_line_buffer u_dut (
    .clk_i                     (clk_i),
    .reset_i                   (reset_i),
    .cs_n_i                    (cs_n),
    .wr_n_i                    (wr_n),
    .dack_n_i                  (dack_n),
    .cmd_sel_i                 (cmd_sel),
    .data_i                    (data),
    .link_clk_i                (link_clk),
    .ser_data_o                (ser_data),
    .ser_clk_o                 (ser_clk),
    .transfer_request_line_n_o (req_n)
  );

  // Peripheral side takes a bit on each rise of the serial clock
  always @(posedge clk_i)
  begin
    sclk_prev <= ser_clk;
    if (ser_clk === 1'b1 && sclk_prev === 1'b0)
      got_q.push_back(ser_data);
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmd(input logic [15:0] w);
    u_host.write_word(1'b1, 1'b0, w);
  endtask

  // Fill bits first, then the stored words in the chosen order
  task automatic add_frame(input int fill, input logic p, input int n);
    int idx;
    for (int i = 0; i < fill; i++)
      exp_q.push_back(p);
    for (int j = 0; j < n; j++)
    begin
      idx = lifo ? n - 1 - j : j;
      for (int b = 0; b < 16; b++)
        exp_q.push_back(words[idx][lsbf ? b : 15 - b]);
    end
  endtask

  task automatic run_frame();
    if (!intc)
      link_run = 1'b1;
    for (k = 0; k < 40000 && got_q.size() < exp_q.size(); k++)
      @(posedge clk_i);
    link_run = 1'b0;
    if (k == 40000)
    begin
      check("frame_timeout", 0, 1);
      stop_test();
    end
    repeat (100) @(posedge clk_i);
    check("bit_count", exp_q.size(), got_q.size());
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      check("serial_bit", exp_q[i], got_q[i]);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("ser_clk_reset", 1, ser_clk);
    check("req_reset", 1, req_n);
    check("ser_data_reset", 0, ser_data);
    void'($urandom(32'h901e0cd4));
    for (it = 0; it < 4; it++)
    begin
      lsbf    = it[0];
      lifo    = it[1];
      intc    = !(it[0] ^ it[1]);
      pre_en  = (it != 2);
      ext32   = (it == 3);
      pol     = 1'($urandom);
      div     = 3'h2 + 3'($urandom % 2);
      pre     = (it < 2) ? 3 : 3 + $urandom % 8;
      // Value below the minimum is expected to act as the minimum
      pre_cmd = (it == 1) ? 2 : pre;
      nw      = 2 + $urandom % 3;
      cmd({4'h8, intc, div, 3'h0, ext32, 1'b0, 1'b1, pre_en, pol});
      cmd({4'h6, 12'(pre_cmd)});
      cmd({4'h7, 3'h0, 9'(nw - 1)});
      cmd({4'h4, 10'h0, lifo, lsbf});
      cmd(16'h0000);
      check("req_write_entry", 0, req_n);
      for (int i = 0; i < nw; i++)
      begin
        words[i] = 16'($urandom);
        u_host.write_word(1'b0, 1'($urandom), words[i]);
        check("req_line", (i == nw - 1), req_n);
      end
      exp_q.delete();
      add_frame(pre_en ? pre + 1 : 0, pol, nw);
      // Repeat enters send mode again, so the preamble comes back too
      if (it >= 2)
        add_frame(pre_en ? pre + 1 : 0, pol, nw);
      got_q.delete();
      if (ext32)
      begin
        cmd(16'h0001);
        repeat (40) @(posedge clk_i);
        check("armed_no_send", 0, got_q.size());
      end
      cmd(16'h0001);
      if (it >= 2)
        cmd(16'h2000);
      if (ext32)
        cmd(16'h0001);
      run_frame();
      cmd(16'hf000);
    end
    // Preamble length survives the stop; fill line uses it
    cmd({4'h8, 1'b1, 3'h0, 3'h0, 2'b00, 1'b1, 1'b1, 1'b1});
    intc = 1'b1;
    cmd(16'h0008);
    check("req_masked", 1, req_n);
    cmd(16'hf000);
    cmd(16'h0008);
    cmd(16'h3001);
    exp_q.delete();
    got_q.delete();
    add_frame(pre + 1 + 32, 1'b1, 0);
    cmd(16'h0001);
    run_frame();
    // Toggle cascade: arm then invert, write to send and back again
    cmd(16'hf000);
    cmd(16'h8808);
    cmd(16'h0000);
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 2; i++)
      begin
        words[i] = 16'($urandom);
        u_host.write_word(1'b0, 1'($urandom), words[i]);
      end
      exp_q.delete();
      got_q.delete();
      // Format from before the stops still applies
      add_frame(0, 1'b0, 2);
      cmd(16'h0004);
      cmd(16'h0006);
      run_frame();
      cmd(16'h0004);
      cmd(16'h0006);
    end
    stop_test();
  end
endmodule
